// *** hdl/module_sideband_control.sv ***
// Sideband control logic of a pluggable transceiver module.
`timescale 1ns/1ps
module module_sideband_control
  import sideband_pkg::*;
#(
  parameter int unsigned RESET_MIN = RESET_MIN_CYCLES
) (
  // Clock, reset and enable.
  input wire logic clk,
  input wire logic rst,
  input wire logic ce,
  // Host-facing control inputs.
  input wire logic module_select_n,
  input wire logic module_reset_n,
  input wire logic low_power_select,
  // Serial clock pin.
  input wire logic scl_in,
  output logic scl_out,
  output logic scl_oe,
  // Serial data pin.
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe,
  // Presence pin.
  output logic module_present_n,
  output logic module_present_oe,
  // Interrupt pin, open collector.
  output logic module_interrupt_n,
  output logic module_interrupt_oe,
  // Internal serial engine side.
  input wire logic scl_stretch,
  input wire logic sda_drive_low,
  output logic serial_enable,
  output logic serial_scl,
  output logic serial_sda,
  // Status and settings from the internal side.
  input wire logic fault_event,
  input wire logic int_ack,
  input wire logic control_wr,
  input wire logic [CTRL_W-1:0] control_wdata,
  output logic [CTRL_W-1:0] control,
  output logic data_not_ready,
  output logic [1:0] int_flags,
  output logic high_power_enable,
  output logic complete_reset
);
  // Carrier to the reset filter.
  sideband_if sb ();
  // Control state and its next value.
  ctrl_state_t state;
  ctrl_state_t next_state;
  // Init timer.
  logic [CNT_W-1:0] timer;
  // Next value of the pending flags.
  logic [1:0] next_flags;

  // Reset pin goes to the filter as it arrives.
  assign sb.reset_pin_n = module_reset_n;

  // Filter for the reset pin.
  reset_pulse_filter #(
    .MIN_CYCLES(RESET_MIN)
  ) u_filter (
    .clk(clk),
    .rst(rst),
    .ce(ce),
    .sb(sb)
  );

  // ==========================================================================
  // Control state machine.
  // ==========================================================================
  // Next state: a qualified reset pulse always wins.
  always_comb begin
    next_state = state;
    case (state)
      ST_INIT: begin
        if (sb.qualified) begin
          next_state = ST_HOLD;
        end else if (timer == INIT_LAST) begin
          next_state = ST_READY;
        end
      end
      ST_HOLD: begin
        if (sb.released) begin
          next_state = ST_INIT;
        end
      end
      ST_READY: begin
        if (sb.qualified) begin
          next_state = ST_HOLD;
        end
      end
      default: begin
        next_state = ST_INIT;
      end
    endcase
  end

  // State register; power-up starts in init without any host pulse.
  always_ff @(posedge clk) begin
    if (rst) begin
      state <= ST_INIT;
    end else if (ce) begin
      state <= next_state;
    end
  end

  // Init timer runs only in init and restarts on every entry.
  always_ff @(posedge clk) begin
    if (rst) begin
      timer <= '0;
    end else if (ce) begin
      if (state == ST_INIT && next_state == ST_INIT) begin
        timer <= timer + CNT_W'(1);
      end else begin
        timer <= '0;
      end
    end
  end

  // Not-ready flag is high from any reset until the module is up.
  always_ff @(posedge clk) begin
    if (rst) begin
      data_not_ready <= 1'b1;
    end else if (ce) begin
      data_not_ready <= (next_state != ST_READY);
    end
  end

  // Complete-reset level for the rest of the module while held.
  always_ff @(posedge clk) begin
    if (rst) begin
      complete_reset <= 1'b1;
    end else if (ce) begin
      complete_reset <= (next_state == ST_HOLD);
    end
  end

  // ==========================================================================
  // Settings.
  // ==========================================================================
  // Settings take writes only when ready; a complete reset restores them.
  always_ff @(posedge clk) begin
    if (rst) begin
      control <= CTRL_DEFAULT;
    end else if (ce) begin
      if (next_state == ST_HOLD) begin
        control <= CTRL_DEFAULT;
      end else if (control_wr && state == ST_READY) begin
        control <= control_wdata;
      end
    end
  end

  // Full power only when the low-power input is low and the module is up.
  always_ff @(posedge clk) begin
    if (rst) begin
      high_power_enable <= 1'b0;
    end else if (ce) begin
      high_power_enable <= !low_power_select && next_state == ST_READY;
    end
  end

  // ==========================================================================
  // Interrupt flags and pin.
  // ==========================================================================
  // Flags: completion on reaching ready, fault while ready; a new event
  // beats an acknowledge in the same cycle, and a reset clears both.
  always_comb begin
    next_flags = int_flags;
    if (int_ack) begin
      next_flags = 2'b00;
    end
    if (state == ST_INIT && next_state == ST_READY) begin
      next_flags[FLAG_DONE] = 1'b1;
    end
    if (fault_event && state == ST_READY) begin
      next_flags[FLAG_FAULT] = 1'b1;
    end
    if (next_state != ST_READY) begin
      next_flags = 2'b00;
    end
  end

  // Flag register.
  always_ff @(posedge clk) begin
    if (rst) begin
      int_flags <= 2'b00;
    end else if (ce) begin
      int_flags <= next_flags;
    end
  end

  // Interrupt pin pulls low while any flag is pending and the module is up.
  always_ff @(posedge clk) begin
    if (rst) begin
      module_interrupt_oe <= 1'b0;
      module_interrupt_n <= 1'b0;
    end else if (ce) begin
      module_interrupt_oe <= (|next_flags) && next_state == ST_READY;
      module_interrupt_n <= 1'b0;
    end
  end

  // ==========================================================================
  // Serial pins and presence.
  // ==========================================================================
  // The two serial pins: engine side and pin drives gated by select.
  always_ff @(posedge clk) begin
    if (rst) begin
      serial_enable <= 1'b0;
      serial_scl <= 1'b1;
      serial_sda <= 1'b1;
      scl_oe <= 1'b0;
      sda_oe <= 1'b0;
    end else if (ce) begin
      serial_enable <= !module_select_n;
      serial_scl <= module_select_n ? 1'b1 : scl_in;
      serial_sda <= module_select_n ? 1'b1 : sda_in;
      scl_oe <= !module_select_n && scl_stretch;
      sda_oe <= !module_select_n && sda_drive_low;
    end
  end

  // Open-drain outputs only ever pull low; presence always pulls.
  always_ff @(posedge clk) begin
    if (rst) begin
      scl_out <= 1'b0;
      sda_out <= 1'b0;
      module_present_n <= 1'b0;
      module_present_oe <= 1'b1;
    end else if (ce) begin
      scl_out <= 1'b0;
      sda_out <= 1'b0;
      module_present_n <= 1'b0;
      module_present_oe <= 1'b1;
    end
  end

  // ==========================================================================
  // Checks.
  // ==========================================================================
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);

  // Last cycle of init with no reset pulse pending.
  sequence init_end_s;
    state == ST_INIT && timer == INIT_LAST && ce && !sb.qualified;
  endsequence

  // A reset pulse being qualified in an enabled cycle.
  sequence hold_start_s;
    ce && sb.qualified && state != ST_HOLD;
  endsequence

  sda_gate_a: assert property (sda_oe |-> serial_enable)
    else $error("Data line driven while not selected.");
  select_track_a: assert property (ce && module_select_n |=> !serial_enable && serial_sda)
    else $error("Serial traffic passed while deselected.");
  hold_defaults_a: assert property (hold_start_s |=>
    complete_reset && data_not_ready && control == CTRL_DEFAULT && !module_interrupt_oe)
    else $error("Qualified reset did not restore defaults.");
  int_ready_a: assert property (module_interrupt_oe |-> !data_not_ready && |int_flags)
    else $error("Interrupt raised while not ready.");
  powerup_done_a: assert property (init_end_s |=>
    module_interrupt_oe && !data_not_ready && int_flags[FLAG_DONE])
    else $error("Completion interrupt missing after init.");
  power_cap_a: assert property (ce && low_power_select |=> !high_power_enable)
    else $error("Full power allowed in low-power mode.");
  present_drive_a: assert property (module_present_oe && !module_present_n)
    else $error("Presence line not pulled low.");
  fault_int_a: assert property (ce && fault_event && state == ST_READY && !sb.qualified |=>
    module_interrupt_oe && int_flags[FLAG_FAULT])
    else $error("Fault did not raise the interrupt.");
endmodule // module_sideband_control

// *** hdl/reset_pulse_filter.sv ***
// Filter that qualifies low pulses on the module reset pin.
`timescale 1ns/1ps
module reset_pulse_filter
  import sideband_pkg::*;
#(
  parameter int unsigned MIN_CYCLES = RESET_MIN_CYCLES
) (
  // Clock, reset and enable.
  input wire logic clk,
  input wire logic rst,
  input wire logic ce,
  // Reset pin and qualified result.
  sideband_if.filt sb
);
  // Cycles the pin has been low, held at the least length once qualified.
  logic [CNT_W-1:0] low_cnt;
  // Independent run length used only by the check below.
  logic [CNT_W-1:0] low_run;

  // ==========================================================================
  // Pulse qualification.
  // ==========================================================================
  // Count low cycles; a pulse qualifies only after the least length.
  always_ff @(posedge clk) begin
    if (rst) begin
      low_cnt <= '0;
      sb.qualified <= 1'b0;
      sb.released <= 1'b0;
    end else if (ce) begin
      if (sb.reset_pin_n) begin
        // Pin high: a short pulse is simply forgotten.
        low_cnt <= '0;
        sb.qualified <= 1'b0;
        sb.released <= sb.qualified;
      end else begin
        if (!sb.qualified) begin
          low_cnt <= low_cnt + CNT_W'(1);
        end
        sb.qualified <= sb.qualified | (low_cnt == CNT_W'(MIN_CYCLES - 1));
        sb.released <= 1'b0;
      end
    end
  end

  // Helper run length of the low level, saturating.
  always_ff @(posedge clk) begin
    if (rst) begin
      low_run <= '0;
    end else if (ce) begin
      if (sb.reset_pin_n) begin
        low_run <= '0;
      end else if (low_run != '1) begin
        low_run <= low_run + CNT_W'(1);
      end
    end
  end

  // A qualified pulse has really been low for the least length.
  short_pulse_a: assert property (@(posedge clk) disable iff (rst)
    sb.qualified |-> low_run >= CNT_W'(MIN_CYCLES))
    else $error("Reset qualified before the least pulse length.");
endmodule // reset_pulse_filter

// *** inc/sideband_if.sv ***
// Carrier between the control logic and the reset pulse filter.
`timescale 1ns/1ps
interface sideband_if;
  // Reset pin level, active low.
  logic reset_pin_n;
  // Reset pin has been low for at least the least pulse length.
  logic qualified;
  // One-cycle pulse when a qualified reset pulse ends.
  logic released;
  modport filt (input reset_pin_n, output qualified, output released);
  modport ctrl (output reset_pin_n, input qualified, input released);
endinterface

// *** inc/sideband_pkg.sv ***
// Shared constants and types for the module sideband control logic.
// Functional notes
// - Provide seven low-speed management pins.
// - Answer serial traffic only while selected.
// - Long reset pulse restores all defaults.
// - Completion interrupt with not-ready flag cleared.
// - Power-up raises completion interrupt unprompted.
// - Low-power input caps power consumption.
// - Presence line pulled to ground when inserted.
// - Interrupt low reports fault or critical status.
package sideband_pkg;
  // ==========================================================================
  // Timing.
  // ==========================================================================
  // Clock period in nanoseconds.
  localparam int unsigned CLK_PERIOD_NS = 50;
  // Least reset pulse length in nanoseconds.
  localparam int unsigned RESET_MIN_NS = 10000;
  // Least reset pulse in cycles, rounded up.
  localparam int unsigned RESET_MIN_CYCLES = (RESET_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  // Time the module takes to come up after a reset, in nanoseconds.
  localparam int unsigned INIT_TIME_NS = 2000;
  // Init time in cycles, rounded up.
  localparam int unsigned INIT_CYCLES = (INIT_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  // Width of the counters.
  localparam int unsigned CNT_W = 16;
  // Last value of the init timer.
  localparam logic [CNT_W-1:0] INIT_LAST = CNT_W'(INIT_CYCLES - 1);
  // ==========================================================================
  // Settings.
  // ==========================================================================
  // Width of the control settings byte.
  localparam int unsigned CTRL_W = 8;
  // Control settings value after reset.
  localparam logic [CTRL_W-1:0] CTRL_DEFAULT = 8'h00;
  // Flag bit positions in the pending interrupt flags.
  localparam int unsigned FLAG_DONE = 0;
  localparam int unsigned FLAG_FAULT = 1;
  // Control states.
  typedef enum logic [1:0] {
    ST_INIT = 2'b00,
    ST_HOLD = 2'b01,
    ST_READY = 2'b10
  } ctrl_state_t;
endpackage

// *** verification/host_board_model.sv ***
// Host board model: drives the control pins and resolves the pulled-up lines.
`timescale 1ns/1ps
module host_board_model (
  // Clock.
  input wire logic clk,
  // Module side of the open-drain pins.
  input wire logic scl_out,
  input wire logic scl_oe,
  input wire logic sda_out,
  input wire logic sda_oe,
  input wire logic module_present_n,
  input wire logic module_present_oe,
  input wire logic module_interrupt_n,
  input wire logic module_interrupt_oe,
  // Host-driven control pins.
  output logic module_select_n,
  output logic module_reset_n,
  output logic low_power_select,
  // Resolved line levels.
  output logic scl_line,
  output logic sda_line,
  output logic present_line,
  output logic interrupt_line
);
  // =========================================================================
  // Host drive state.
  // =========================================================================
  logic sel_n; // One select line for this one module only.
  logic rst_n; // Reset pin level.
  logic lp; // Low-power request.
  logic scl_low; // Host pulls the clock line low.
  logic sda_low; // Host pulls the data line low.
  // Lines start deselected, out of reset and released.
  initial begin
    sel_n = 1'b1;
    rst_n = 1'b1;
    lp = 1'b0;
    scl_low = 1'b0;
    sda_low = 1'b0;
  end
  assign module_select_n = sel_n;
  assign module_reset_n = rst_n;
  assign low_power_select = lp;
  // Pull-ups hold every line high unless some party pulls it low.
  assign scl_line = !((scl_oe && !scl_out) || scl_low);
  assign sda_line = !((sda_oe && !sda_out) || sda_low);
  assign present_line = !(module_present_oe && !module_present_n);
  assign interrupt_line = !(module_interrupt_oe && !module_interrupt_n);
  // =========================================================================
  // Host actions, each called just after a rising edge.
  // =========================================================================
  // Addresses this module alone by its own select line.
  task automatic select_module(input logic v);
    sel_n = v;
  endtask
  // Sets the reset pin level.
  task automatic hold_reset(input logic v);
    rst_n = v;
  endtask
  // Holds the reset pin low for n cycles, then releases it.
  task automatic pulse_reset(input int n);
    rst_n = 1'b0;
    repeat (n) @(posedge clk);
    #1;
    rst_n = 1'b1;
  endtask
  // Sets the low-power request.
  task automatic set_low_power(input logic v);
    lp = v;
  endtask
  // Pulls or releases the serial data line.
  task automatic drive_sda(input logic low);
    sda_low = low;
  endtask
endmodule // host_board_model

// *** verification/tb_module_sideband_control.sv ***
// Self-checking bench for the module sideband control logic.
`timescale 1ns/1ps
module tb_module_sideband_control;
  import sideband_pkg::*;
  // =========================================================================
  // Signals.
  // =========================================================================
  localparam int unsigned RMIN = 4; // Shortened reset qualification length.
  logic clk = 1'b0;
  logic rst, ce, scl_stretch, sda_drive_low, fault_event, int_ack, control_wr; // Driven by the main sequence.
  logic [CTRL_W-1:0] control_wdata; // Settings write data.
  logic module_select_n, module_reset_n, low_power_select, scl_in, sda_in;
  logic scl_out, scl_oe, sda_out, sda_oe, module_present_n, module_present_oe;
  logic module_interrupt_n, module_interrupt_oe, serial_enable, serial_scl, serial_sda;
  logic [CTRL_W-1:0] control;
  logic data_not_ready, high_power_enable, complete_reset, present_line, interrupt_line;
  logic [1:0] int_flags;
  int miscompares = 0; // Mismatches seen.
  int checks_done = 0; // Comparisons made.
  int n; // Cycles waited for the interrupt.
  always #25 clk = ~clk;
  // =========================================================================
  // Design and host model.
  // =========================================================================
  module_sideband_control #(.RESET_MIN(RMIN)) uut (.clk(clk), .rst(rst), .ce(ce),
    .module_select_n(module_select_n), .module_reset_n(module_reset_n),
    .low_power_select(low_power_select), .scl_in(scl_in), .scl_out(scl_out), .scl_oe(scl_oe),
    .sda_in(sda_in), .sda_out(sda_out), .sda_oe(sda_oe), .module_present_n(module_present_n),
    .module_present_oe(module_present_oe), .module_interrupt_n(module_interrupt_n),
    .module_interrupt_oe(module_interrupt_oe), .scl_stretch(scl_stretch),
    .sda_drive_low(sda_drive_low), .serial_enable(serial_enable), .serial_scl(serial_scl),
    .serial_sda(serial_sda), .fault_event(fault_event), .int_ack(int_ack),
    .control_wr(control_wr), .control_wdata(control_wdata), .control(control),
    .data_not_ready(data_not_ready), .int_flags(int_flags),
    .high_power_enable(high_power_enable), .complete_reset(complete_reset));
  host_board_model host (.clk(clk), .scl_out(scl_out), .scl_oe(scl_oe), .sda_out(sda_out),
    .sda_oe(sda_oe), .module_present_n(module_present_n), .module_present_oe(module_present_oe),
    .module_interrupt_n(module_interrupt_n), .module_interrupt_oe(module_interrupt_oe),
    .module_select_n(module_select_n), .module_reset_n(module_reset_n),
    .low_power_select(low_power_select), .scl_line(scl_in), .sda_line(sda_in),
    .present_line(present_line), .interrupt_line(interrupt_line));
  // =========================================================================
  // Tasks.
  // =========================================================================
  // Waits k rising edges, then 1 ns for the outputs to settle.
  task automatic step(input int k);
    repeat (k) @(posedge clk);
    #1;
  endtask
  // Compares a seen value against the expected one.
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    checks_done++;
    if (seen !== exp) begin
      miscompares++;
      $display("FAIL t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  // Prints the verdict and ends the run.
  task automatic end_of_test;
    if (miscompares == 0 && checks_done > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  // Waits, bounded, for the interrupt line to go low; status is ignored meanwhile.
  task automatic wait_int(output int k);
    k = 0;
    while (interrupt_line !== 1'b0) begin
      if (k > 100) begin
        miscompares++;
        end_of_test();
      end
      step(1);
      k++;
    end
  endtask
  // Reads the status, clearing the pending flags.
  task automatic read_status;
    int_ack = 1'b1;
    step(1);
    int_ack = 1'b0;
  endtask
  // =========================================================================
  // Main sequence.
  // =========================================================================
  initial begin
    rst = 1'b1;
    ce = 1'b1;
    scl_stretch = 1'b0;
    sda_drive_low = 1'b0;
    fault_event = 1'b0;
    int_ack = 1'b0;
    control_wr = 1'b0;
    control_wdata = 8'h00;
    step(6);
    rst = 1'b0;
    check(8'(data_not_ready), 8'h01);
    fault_event = 1'b1;
    step(1);
    fault_event = 1'b0;
    wait_int(n);
    check(8'(n >= INIT_CYCLES - 2), 8'h01);
    check(8'(int_flags), 8'h01);
    check(8'(data_not_ready), 8'h00);
    check(8'(present_line), 8'h00);
    read_status();
    check(8'(int_flags), 8'h00);
    check(8'(interrupt_line), 8'h01);
    // Settings write and power cap.
    control_wr = 1'b1;
    control_wdata = 8'hA5;
    step(1);
    control_wr = 1'b0;
    check(control, 8'hA5);
    check(8'(high_power_enable), 8'h01);
    host.set_low_power(1'b1);
    step(1);
    check(8'(high_power_enable), 8'h00);
    host.set_low_power(1'b0);
    // A frozen clock enable drops the fault.
    ce = 1'b0;
    fault_event = 1'b1;
    step(2);
    fault_event = 1'b0;
    ce = 1'b1;
    step(1);
    check(8'(int_flags), 8'h00);
    fault_event = 1'b1;
    step(1);
    fault_event = 1'b0;
    check(8'(int_flags), 8'h02);
    check(8'(interrupt_line), 8'h00);
    read_status();
    check(8'(interrupt_line), 8'h01);
    // A pulse one cycle too short is ignored.
    host.pulse_reset(RMIN - 1);
    step(3);
    check(control, 8'hA5);
    check(8'(data_not_ready), 8'h00);
    check(8'(complete_reset), 8'h00);
    // A long pulse restores defaults and refuses writes while held.
    host.hold_reset(1'b0);
    step(RMIN + 3);
    check(8'(complete_reset), 8'h01);
    check(control, 8'h00);
    check(8'(data_not_ready), 8'h01);
    check(8'(high_power_enable), 8'h00);
    control_wr = 1'b1;
    step(1);
    control_wr = 1'b0;
    check(control, 8'h00);
    host.hold_reset(1'b1);
    wait_int(n);
    check(8'(int_flags), 8'h01);
    check(8'(data_not_ready), 8'h00);
    read_status();
    // Serial access only while selected.
    host.drive_sda(1'b1);
    sda_drive_low = 1'b1;
    scl_stretch = 1'b1;
    step(2);
    check(8'({serial_enable, serial_scl, serial_sda, sda_oe, scl_oe}), 8'h0C);
    host.select_module(1'b0);
    step(2);
    check(8'({serial_enable, serial_scl, serial_sda, sda_oe, scl_oe}), 8'h13);
    host.select_module(1'b1);
    host.drive_sda(1'b0);
    step(2);
    check(8'({serial_enable, serial_scl, serial_sda, sda_oe, scl_oe}), 8'h0C);
    end_of_test();
  end
endmodule // tb_module_sideband_control
